// file: src/sfpp_core.v
/*
 * Device-side access control of a serial flash: SPI mode 0/3 front end
 * sampled by core_clk, write-enable latch, protection, pause, status
 * polling and a two-entry buffer of requests to the flash array.
 * Assumes the array takes requests by valid/ready and pulses arr_done
 * once when the whole program or erase cycle has ended.
 */
`timescale 1ns/1ps
`include "sfpp_defines.vh"

module sfpp_core #(
    parameter ADDR_W = 24,
    parameter PUW_US = `SFPP_PUW_US,
    parameter SRW_US = `SFPP_SRW_US,
    parameter PUW_CYCLES = PUW_US * `SFPP_CLK_MHZ,
    parameter SRW_CYCLES = SRW_US * `SFPP_CLK_MHZ
) (
    // Clock and reset
    input wire core_clk,
    input wire resetn,
    // Serial pins
    input wire spi_sclk,
    input wire spi_cs_n,
    input wire spi_mosi,
    input wire pause_n,
    input wire wp_n,
    input wire hv_detect,
    input wire supply_ok,
    output reg spi_miso,
    output reg spi_miso_oe,
    // Array request stream
    output reg arr_valid,
    input wire arr_ready,
    output reg [1:0] arr_kind,
    output reg [ADDR_W-1:0] arr_addr,
    output reg [7:0] arr_data,
    input wire arr_done,
    // Status
    output reg write_enable_latch,
    output reg write_in_progress,
    output reg [2:0] protect_code,
    output reg status_write_disable,
    output reg hardware_protected_mode,
    output reg fast_mode,
    output reg active_power,
    output reg paused
);

    // ****************************************
    // Local constants
    // ****************************************
    localparam NPIN = 7;
    localparam P_SCLK = 0;
    localparam P_CS = 1;
    localparam P_MOSI = 2;
    localparam P_PAUSE = 3;
    localparam P_WP = 4;
    localparam P_HV = 5;
    localparam P_SUP = 6;
    localparam ENTRY_W = 2 + ADDR_W + 8;
    localparam [NPIN-1:0] PIN_IDLE = `SFPP_PIN_IDLE;
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_TIMER = 4'b0010;
    localparam [3:0] ST_FEED = 4'b0100;
    localparam [3:0] ST_WAIT = 4'b1000;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    wire [NPIN-1:0] pin_raw;
    reg [NPIN-1:0] meta_reg;
    reg [NPIN-1:0] pin_reg;
    reg sclk_d_reg;
    reg cs_d_reg;

    assign pin_raw = {supply_ok, hv_detect, wp_n, pause_n, spi_mosi,
                      spi_cs_n, spi_sclk};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
            always @(posedge core_clk) begin
                if (!resetn) begin
                    // Idle levels, so reset shows no false select or pause
                    meta_reg[gi] <= PIN_IDLE[gi];
                    pin_reg[gi] <= PIN_IDLE[gi];
                end else begin
                    meta_reg[gi] <= pin_raw[gi];
                    pin_reg[gi] <= meta_reg[gi];
                end
            end
        end
    endgenerate

    always @(posedge core_clk) begin
        if (!resetn) begin
            sclk_d_reg <= 1'b0;
            cs_d_reg <= 1'b1;
        end else begin
            sclk_d_reg <= pin_reg[P_SCLK];
            cs_d_reg <= pin_reg[P_CS];
        end
    end

    // Edges of the link clock; same for mode 0 and mode 3
    wire selected = ~pin_reg[P_CS];
    wire sclk_rise = pin_reg[P_SCLK] & ~sclk_d_reg;
    wire sclk_fall = ~pin_reg[P_SCLK] & sclk_d_reg;
    wire cs_rise = pin_reg[P_CS] & ~cs_d_reg;
    wire live = selected & ~paused;

    // ****************************************
    // Protection decode
    // ****************************************
    function prot_hit;
        input [2:0] code;
        input [5:0] sector;
        reg [6:0] size;
        begin
            size = 7'h00;
            if (code != `SFPP_BP_NONE)
                size = 7'h01 << (code - 3'h1);
            if (code == `SFPP_BP_ALL)
                prot_hit = 1'b1;
            else
                prot_hit = ({1'b0, sector} >= (`SFPP_SECTOR_COUNT - size))
                           && (code != `SFPP_BP_NONE);
        end
    endfunction

    // ****************************************
    // Shift-in path
    // ****************************************
    reg [6:0] shift_reg;
    reg [2:0] bit_cnt_reg;
    reg [2:0] byte_cnt_reg;
    reg [7:0] opcode_reg;
    reg [ADDR_W-1:0] addr_reg;
    reg [7:0] sr_data_reg;
    reg [7:0] wptr_reg;
    reg [8:0] data_cnt_reg;
    reg [7:0] page_mem [0:255];
    wire [7:0] byte_in = {shift_reg, pin_reg[P_MOSI]};
    wire byte_done = live & sclk_rise & (bit_cnt_reg == `SFPP_LAST_BIT);

    always @(posedge core_clk) begin
        if (!resetn || !selected) begin
            shift_reg <= 7'h00;
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 3'h0;
        end else if (live && sclk_rise) begin
            shift_reg <= byte_in[6:0];
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (byte_done && byte_cnt_reg != `SFPP_LEN_WITH_DATA)
                byte_cnt_reg <= byte_cnt_reg + 3'h1;
        end
    end

    // Words of the current selection; page bytes wrap inside the page
    always @(posedge core_clk) begin
        if (!resetn) begin
            opcode_reg <= 8'h00;
            addr_reg <= {ADDR_W{1'b0}};
            sr_data_reg <= 8'h00;
            wptr_reg <= 8'h00;
            data_cnt_reg <= 9'h000;
        end else if (byte_done) begin
            case (byte_cnt_reg)
                3'h0: begin
                    opcode_reg <= byte_in;
                    data_cnt_reg <= 9'h000;
                end
                3'h1: begin
                    sr_data_reg <= byte_in;
                    addr_reg <= {byte_in, addr_reg[ADDR_W-9:0]};
                end
                3'h2: addr_reg[ADDR_W-9:ADDR_W-16] <= byte_in;
                3'h3: begin
                    addr_reg[7:0] <= byte_in;
                    wptr_reg <= byte_in;
                end
                default: begin
                    wptr_reg <= wptr_reg + 8'h01;
                    if (data_cnt_reg != `SFPP_PAGE_BYTES)
                        data_cnt_reg <= data_cnt_reg + 9'h001;
                end
            endcase
        end
    end

    // Page data is frozen while a cycle reads it out
    always @(posedge core_clk) begin
        if (byte_done && !write_in_progress &&
            byte_cnt_reg >= `SFPP_LEN_ADDRESSED)
            page_mem[wptr_reg] <= byte_in;
    end

    // ****************************************
    // Pause condition
    // ****************************************
    // Pause follows the pin only while the clock is low, so an edge on
    // the pin during a high clock waits for the clock to drop
    always @(posedge core_clk) begin
        if (!resetn || !selected)
            paused <= 1'b0;
        else if (!pin_reg[P_SCLK])
            paused <= ~pin_reg[P_PAUSE];
    end

    // ****************************************
    // Status read path
    // ****************************************
    reg rd_active_reg;
    reg [2:0] rd_idx_reg;
    wire [7:0] status_now = {status_write_disable, 2'b00, protect_code,
                             write_enable_latch, write_in_progress};

    always @(posedge core_clk) begin
        if (!resetn || !selected) begin
            rd_active_reg <= 1'b0;
            rd_idx_reg <= `SFPP_LAST_BIT;
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else begin
            spi_miso_oe <= rd_active_reg & ~paused;
            if (byte_done && byte_cnt_reg == 3'h0 &&
                byte_in == `SFPP_OP_STATUS_READ)
                rd_active_reg <= 1'b1;
            if (live && sclk_fall && rd_active_reg) begin
                spi_miso <= status_now[rd_idx_reg];
                rd_idx_reg <= rd_idx_reg - 3'h1;
            end
        end
    end

    // ****************************************
    // Power-up lockout
    // ****************************************
    reg [31:0] puw_cnt_reg;
    reg power_ok_reg;

    always @(posedge core_clk) begin
        if (!resetn || !pin_reg[P_SUP]) begin
            puw_cnt_reg <= 32'h0000_0000;
            power_ok_reg <= 1'b0;
        end else if (puw_cnt_reg == PUW_CYCLES) begin
            power_ok_reg <= 1'b1;
        end else begin
            puw_cnt_reg <= puw_cnt_reg + 32'h0000_0001;
        end
    end

    // ****************************************
    // Command acceptance
    // ****************************************
    // A deselect while paused resets the interface and executes nothing
    wire at_end = cs_rise & ~paused & (bit_cnt_reg == 3'h0)
                  & ~write_in_progress & power_ok_reg;
    wire sector_prot = prot_hit(protect_code,
                                addr_reg[ADDR_W-1:ADDR_W-6]);
    wire go_latch = at_end & (opcode_reg == `SFPP_OP_WRITE_ENABLE)
                    & (byte_cnt_reg == `SFPP_LEN_OPCODE);
    wire go_unlatch = at_end & (opcode_reg == `SFPP_OP_WRITE_DISABLE)
                      & (byte_cnt_reg == `SFPP_LEN_OPCODE);
    wire go_srw = at_end & write_enable_latch
                  & (opcode_reg == `SFPP_OP_STATUS_WRITE)
                  & (byte_cnt_reg >= `SFPP_LEN_STATUS_WRITE);
    wire go_prog = at_end & write_enable_latch & ~sector_prot
                 & (opcode_reg == `SFPP_OP_PAGE_PROGRAM)
                 & (byte_cnt_reg == `SFPP_LEN_WITH_DATA);
    wire go_sect = at_end & write_enable_latch & ~sector_prot
                 & (opcode_reg == `SFPP_OP_SECTOR_ERASE)
                 & (byte_cnt_reg == `SFPP_LEN_ADDRESSED);
    wire go_bulk = at_end & write_enable_latch
                 & (protect_code == `SFPP_BP_NONE)
                 & (opcode_reg == `SFPP_OP_BULK_ERASE)
                 & (byte_cnt_reg == `SFPP_LEN_OPCODE);

    // ****************************************
    // Cycle engine
    // ****************************************
    reg [3:0] state_reg;
    reg [31:0] timer_reg;
    reg [1:0] kind_reg;
    reg [7:0] feed_ptr_reg;
    reg [8:0] feed_left_reg;
    reg skid_valid_reg;
    reg [ENTRY_W-1:0] skid_reg;
    wire buf_ready = ~skid_valid_reg;
    wire feed_push = state_reg[2] & buf_ready;
    wire [7:0] feed_byte = (kind_reg == `SFPP_KIND_PROGRAM) ?
                           page_mem[feed_ptr_reg] : `SFPP_ERASED_BYTE;
    wire [ENTRY_W-1:0] feed_entry = {kind_reg,
                                     addr_reg[ADDR_W-1:8], feed_ptr_reg,
                                     feed_byte};

    always @(posedge core_clk) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            timer_reg <= 32'h0000_0000;
            kind_reg <= 2'h0;
            feed_ptr_reg <= 8'h00;
            feed_left_reg <= 9'h000;
            write_in_progress <= 1'b0;
            write_enable_latch <= 1'b0;
            protect_code <= 3'h0;
            status_write_disable <= 1'b0;
        end else if (!power_ok_reg) begin
            write_enable_latch <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (go_latch)
                        write_enable_latch <= 1'b1;
                    if (go_unlatch)
                        write_enable_latch <= 1'b0;
                    if (go_srw) begin
                        // Write protect freezes these bits; cycle still runs
                        if (pin_reg[P_WP]) begin
                            protect_code <= sr_data_reg[`SFPP_ST_BP_HI:
                                                        `SFPP_ST_BP_LO];
                            status_write_disable <= sr_data_reg[`SFPP_ST_SWD];
                        end
                        timer_reg <= SRW_CYCLES;
                        write_in_progress <= 1'b1;
                        state_reg <= ST_TIMER;
                    end
                    if (go_prog || go_sect || go_bulk) begin
                        write_in_progress <= 1'b1;
                        state_reg <= ST_FEED;
                    end
                    if (go_prog) begin
                        kind_reg <= `SFPP_KIND_PROGRAM;
                        feed_ptr_reg <= addr_reg[7:0];
                        feed_left_reg <= data_cnt_reg;
                    end
                    if (go_sect || go_bulk) begin
                        kind_reg <= go_sect ? `SFPP_KIND_SECTOR
                                          : `SFPP_KIND_BULK;
                        feed_ptr_reg <= addr_reg[7:0];
                        feed_left_reg <= 9'h001;
                    end
                end
                ST_TIMER: begin
                    if (timer_reg == 32'h0000_0000) begin
                        write_in_progress <= 1'b0;
                        write_enable_latch <= 1'b0;
                        state_reg <= ST_IDLE;
                    end else begin
                        timer_reg <= timer_reg - 32'h0000_0001;
                    end
                end
                ST_FEED: begin
                    if (feed_push) begin
                        feed_ptr_reg <= feed_ptr_reg + 8'h01;
                        feed_left_reg <= feed_left_reg - 9'h001;
                        if (feed_left_reg == 9'h001)
                            state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // Deselect, pause and new commands leave this alone
                    if (arr_done) begin
                        write_in_progress <= 1'b0;
                        write_enable_latch <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Two-entry request buffer
    // ****************************************
    // Output stage plus skid entry: a stalled array never drops a byte,
    // and a full skid entry stops the feed above
    wire buf_pop = arr_valid & arr_ready;

    always @(posedge core_clk) begin
        if (!resetn) begin
            arr_valid <= 1'b0;
            arr_kind <= 2'h0;
            arr_addr <= {ADDR_W{1'b0}};
            arr_data <= 8'h00;
            skid_valid_reg <= 1'b0;
            skid_reg <= {ENTRY_W{1'b0}};
        end else if (buf_pop && skid_valid_reg) begin
            {arr_kind, arr_addr, arr_data} <= skid_reg;
            skid_valid_reg <= 1'b0;
        end else if (buf_pop || !arr_valid) begin
            arr_valid <= feed_push;
            if (feed_push)
                {arr_kind, arr_addr, arr_data} <= feed_entry;
        end else if (feed_push) begin
            skid_reg <= feed_entry;
            skid_valid_reg <= 1'b1;
        end
    end

    // ****************************************
    // Power mode, supply mode and protection mode flags
    // ****************************************
    always @(posedge core_clk) begin
        if (!resetn) begin
            active_power <= 1'b0;
            fast_mode <= 1'b0;
            hardware_protected_mode <= 1'b0;
        end else begin
            active_power <= selected | write_in_progress;
            fast_mode <= pin_reg[P_HV] & write_in_progress
                         & ~state_reg[1];
            hardware_protected_mode <= ~pin_reg[P_WP];
        end
    end

endmodule

// file: shared/sfpp_defines.vh
/*
 * Constants for the serial flash protect and pause block: opcodes,
 * status bit positions, array request kinds and timing figures.
 * Assumes it is included by its bare name from the design file.
 */
`ifndef SFPP_DEFINES_VH
`define SFPP_DEFINES_VH

// ****************************************
// Opcodes
// ****************************************
`define SFPP_OP_WRITE_ENABLE 8'h06
`define SFPP_OP_WRITE_DISABLE 8'h04
`define SFPP_OP_STATUS_READ 8'h05
`define SFPP_OP_STATUS_WRITE 8'h01
`define SFPP_OP_PAGE_PROGRAM 8'h02
`define SFPP_OP_SECTOR_ERASE 8'hD8
`define SFPP_OP_BULK_ERASE 8'hC7

// ****************************************
// Byte counts of a selection
// ****************************************
`define SFPP_LEN_OPCODE 3'h1
`define SFPP_LEN_STATUS_WRITE 3'h2
`define SFPP_LEN_ADDRESSED 3'h4
`define SFPP_LEN_WITH_DATA 3'h5
`define SFPP_ADDR_LOW_BYTE 3'h3
`define SFPP_LAST_BIT 3'h7
`define SFPP_PAGE_BYTES 9'h100

// ****************************************
// Status byte layout
// ****************************************
`define SFPP_ST_BUSY 0
`define SFPP_ST_LATCH 1
`define SFPP_ST_BP_LO 2
`define SFPP_ST_BP_HI 4
`define SFPP_ST_SWD 7

// ****************************************
// Protection and array requests
// ****************************************
`define SFPP_SECTOR_COUNT 7'h40
`define SFPP_BP_NONE 3'h0
`define SFPP_BP_ALL 3'h7
`define SFPP_ERASED_BYTE 8'hFF
`define SFPP_KIND_PROGRAM 2'h1
`define SFPP_KIND_SECTOR 2'h2
`define SFPP_KIND_BULK 2'h3

// ****************************************
// Timing
// ****************************************
`define SFPP_CLK_MHZ 100
`define SFPP_PUW_US 10
`define SFPP_SRW_US 20

// ****************************************
// Pin idle levels, {supply, hv, wp, pause, mosi, cs, sclk}
// ****************************************
`define SFPP_PIN_IDLE 7'h1A

`endif

// file: testbench/sfpp_checker.sv
/* Assertions on the ports of sfpp_core.
   Assumes it is bound to every sfpp_core instance. */
`timescale 1ns/1ps
module sfpp_checker #(
    parameter ADDR_W = 24
) (
    // Clock and reset
    input wire core_clk,
    input wire resetn,
    // Inputs watched
    input wire supply_ok,
    input wire arr_ready,
    // Outputs watched
    input wire spi_miso_oe,
    input wire arr_valid,
    input wire [1:0] arr_kind,
    input wire [ADDR_W-1:0] arr_addr,
    input wire [7:0] arr_data,
    input wire write_enable_latch,
    input wire write_in_progress,
    input wire [2:0] protect_code,
    input wire status_write_disable,
    input wire hardware_protected_mode,
    input wire fast_mode,
    input wire active_power,
    input wire paused
);
    wire [6:0] sec = {1'b0, arr_addr[ADDR_W-1 -: 6]};
    wire [6:0] lim = 7'h40 - (7'h01 << (protect_code - 3'h1));
    wire hit = protect_code == 3'h7 || (protect_code != 3'h0 && sec >= lim);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_stall;
        arr_valid && !arr_ready;
    endsequence
    chk_entry_hold: assert property (s_stall |=> arr_valid
        && $stable(arr_addr) && $stable(arr_data)) else $error("entry lost");
    chk_latch_clear: assert property ($fell(write_in_progress)
        |-> ##[0:1] !write_enable_latch) else $error("latch kept");
    chk_hpm_freeze: assert property (hardware_protected_mode
        && $past(hardware_protected_mode) |-> $stable(protect_code)
        && $stable(status_write_disable)) else $error("code changed");
    chk_supply_lock: assert property (!supply_ok [*5]
        |-> !write_enable_latch) else $error("latch without supply");
    chk_active_run: assert property (write_in_progress
        && $past(write_in_progress) |-> active_power) else $error("standby");
    chk_pause_float: assert property (paused [*2] |-> !spi_miso_oe)
        else $error("output driven in pause");
    chk_wip_array: assert property (arr_valid |-> write_in_progress)
        else $error("entry outside cycle");
    chk_bulk_code: assert property (arr_valid && arr_kind == 2'h3
        |-> protect_code == 3'h0) else $error("bulk with protection");
    chk_sector_guard: assert property (arr_valid && arr_kind != 2'h3
        |-> !hit) else $error("protected sector touched");
    chk_erase_byte: assert property (arr_valid && arr_kind != 2'h1
        |-> arr_data == 8'hFF) else $error("erase byte");
    chk_fast_cycle: assert property (fast_mode |-> write_in_progress)
        else $error("fast mode idle");
endmodule
bind sfpp_core sfpp_checker #(.ADDR_W(ADDR_W)) i_sfpp_checker (.*);

// file: testbench/sfpp_array_model.sv
/* Flash array stand-in: takes request entries, stalls on demand and
   pulses arr_done after a quiet gap. Assumes the bench drives stall. */
`timescale 1ns/1ps
module sfpp_array_model (
    // Clock and reset
    input wire core_clk,
    input wire resetn,
    // Request stream
    input wire arr_valid,
    output wire arr_ready,
    input wire [1:0] arr_kind,
    input wire [23:0] arr_addr,
    input wire [7:0] arr_data,
    output reg arr_done,
    // Bench view
    input wire stall,
    output reg [7:0] n_taken,
    output reg [33:0] last_entry
);
    reg [3:0] gap;
    assign arr_ready = !stall;
    // Done only after a quiet gap, so a stalled stream never ends early
    always @(posedge core_clk) begin
        arr_done <= 1'b0;
        if (!resetn) begin
            n_taken <= 8'h00;
            gap <= 4'h0;
        end else if (arr_valid && arr_ready) begin
            n_taken <= n_taken + 8'h01;
            last_entry <= {arr_kind, arr_addr, arr_data};
            gap <= 4'h1;
        end else if (gap != 4'h0 && !arr_valid) begin
            gap <= gap + 4'h1;
            if (gap == 4'h8) begin
                arr_done <= 1'b1;
                gap <= 4'h0;
            end
        end
    end
endmodule

// file: testbench/tb.sv
/* Self-checking bench: drives the serial pins as a mode 0/3 master.
   Assumes sfpp_core, its checker and the array model are compiled. */
`timescale 1ns/1ps
module tb;
    reg core_clk = 1'b0, resetn = 1'b0, spi_sclk = 1'b0, spi_cs_n = 1'b1;
    reg spi_mosi = 1'b0, pause_n = 1'b1, wp_n = 1'b1, hv_detect = 1'b0;
    reg supply_ok = 1'b0, stall = 1'b0, cpol = 1'b0, saw_fast = 1'b0;
    wire spi_miso, spi_miso_oe, arr_valid, arr_ready, arr_done, latch, busy;
    wire swd, hw_prot, fast, act, paused;
    wire [1:0] arr_kind;
    wire [2:0] code;
    wire [7:0] arr_data, n_taken;
    wire [23:0] arr_addr;
    wire [33:0] last_entry;
    reg [7:0] tx [0:7];
    reg [7:0] rx [0:7];
    reg [7:0] n0;
    integer failures = 0, n_tests = 0, c, s;
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (fast) saw_fast <= 1'b1;
    sfpp_core #(.PUW_CYCLES(20), .SRW_CYCLES(600)) i_sfpp_core (
        .core_clk(core_clk), .resetn(resetn), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .pause_n(pause_n),
        .wp_n(wp_n), .hv_detect(hv_detect), .supply_ok(supply_ok),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .arr_valid(arr_valid), .arr_ready(arr_ready), .arr_kind(arr_kind),
        .arr_addr(arr_addr), .arr_data(arr_data), .arr_done(arr_done),
        .write_enable_latch(latch), .write_in_progress(busy),
        .protect_code(code), .status_write_disable(swd),
        .hardware_protected_mode(hw_prot), .fast_mode(fast),
        .active_power(act), .paused(paused));
    sfpp_array_model i_sfpp_array_model (.core_clk(core_clk),
        .resetn(resetn), .arr_valid(arr_valid), .arr_ready(arr_ready),
        .arr_kind(arr_kind), .arr_addr(arr_addr), .arr_data(arr_data),
        .arr_done(arr_done), .stall(stall), .n_taken(n_taken),
        .last_entry(last_entry));
    // ****************************************
    // Tasks
    // ****************************************
    task give_verdict;
        begin
            $display("checks %0d, mismatches %0d", n_tests, failures);
            if (failures == 0 && n_tests > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task check(input string name, input [47:0] exp, input [47:0] got);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("wrong value %0s: expected %h, seen %h", name, exp,
                    got);
            end
        end
    endtask
    task ticks(input integer n);
        repeat (n) @(negedge core_clk);
    endtask
    // One selection of nb clocks, MSB first; pauses before bit hold_at,
    // or, with hold_at equal to nb, pauses and deselects while paused
    task frame(input integer nb, input integer hold_at);
        integer k;
        begin
            spi_sclk = cpol;
            ticks(8);
            spi_cs_n = 1'b0;
            ticks(8);
            for (k = 0; k < nb; k = k + 1) begin
                spi_sclk = 1'b0;
                spi_mosi = tx[k/8][7-k%8];
                if (k == hold_at) begin
                    pause_n = 1'b0;
                    ticks(12);
                    check("pause", 2'b10, {paused, spi_miso_oe});
                    spi_mosi = ~spi_mosi;
                    spi_sclk = 1'b1;
                    ticks(8);
                    spi_sclk = 1'b0;
                    spi_mosi = tx[k/8][7-k%8];
                    pause_n = 1'b1;
                    ticks(8);
                end
                ticks(8);
                spi_sclk = 1'b1;
                rx[k/8][7-k%8] = spi_miso;
                ticks(8);
            end
            spi_sclk = cpol;
            if (hold_at == nb)
                pause_n = 1'b0;
            ticks(8);
            spi_cs_n = 1'b1;
            ticks(24);
            pause_n = 1'b1;
        end
    endtask
    task cmd(input [7:0] op, input [23:0] a, input integer nb);
        begin
            tx[0] = op;
            tx[1] = a[23:16];
            tx[2] = a[15:8];
            tx[3] = a[7:0];
            frame(nb, -1);
        end
    endtask
    task wait_idle;
        integer t;
        begin
            for (t = 0; busy !== 1'b0 && t < 5000; t = t + 1)
                ticks(1);
            if (t == 5000) begin
                failures = failures + 1;
                give_verdict;
            end
        end
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        tx[4] = 8'h00;
        ticks(3);
        resetn = 1'b1;
        cmd(8'h06, 24'h00_0000, 8);
        check("latch lock", 0, latch);
        supply_ok = 1'b1;
        ticks(40);
        cpol = 1'b1;
        cmd(8'h06, 24'h00_0000, 8);
        check("latch set", 1, latch);
        cpol = 1'b0;
        cmd(8'h04, 24'h00_0000, 8);
        check("latch clear", 0, latch);
        cmd(8'h01, 24'h1C_0000, 16);
        ticks(700);
        check("no latch", 0, code);
        cmd(8'h06, 24'h00_0000, 8);
        n0 = n_taken;
        cmd(8'hD8, 24'h00_0000, 33);
        check("odd bits", {n0, 1'b1}, {n_taken, latch});
        $display("test latch done");
        cmd(8'h01, 24'h9C_0000, 16);
        cmd(8'h05, 24'h00_0000, 16);
        check("poll", 2'b11, rx[1][1:0]);
        check("active", 1, act);
        wait_idle;
        cmd(8'h05, 24'h00_0000, 16);
        check("status", 8'h9C, rx[1]);
        check("standby", 0, act);
        cmd(8'h06, 24'h00_0000, 8);
        cmd(8'hC7, 24'h00_0000, 8);
        check("bulk refused", {n0, 2'b01}, {n_taken, busy, latch});
        $display("test status done");
        for (c = 1; c < 8; c = c + 1) begin
            cmd(8'h06, 24'h00_0000, 8);
            cmd(8'h01, {3'b000, c[2:0], 18'h0_0000}, 16);
            wait_idle;
            cmd(8'h06, 24'h00_0000, 8);
            n0 = n_taken;
            s = (c == 7) ? 0 : 64 - (1 << (c - 1));
            cmd(8'hD8, {s[5:0], 18'h0_0000}, 32);
            check("top sector", n0, n_taken);
            if (c < 7) begin
                cmd(8'hD8, {s[5:0] - 6'h01, 18'h0_0000}, 32);
                wait_idle;
                check("erase", {n0 + 8'h01, 2'h2, 8'hFF},
                    {n_taken, last_entry[33:32], last_entry[7:0]});
            end
        end
        $display("test protect done");
        wp_n = 1'b0;
        cmd(8'h06, 24'h00_0000, 8);
        tx[0] = 8'h05;
        frame(16, 12);
        check("paused read", 8'h1E, rx[1]);
        cmd(8'h01, 24'h00_0000, 16);
        wait_idle;
        check("frozen", {1'b1, 3'h7, 1'b0}, {hw_prot, code, latch});
        tx[0] = 8'h06;
        frame(8, 8);
        check("paused deselect", 0, latch);
        wp_n = 1'b1;
        cmd(8'h06, 24'h00_0000, 8);
        cmd(8'h01, 24'h00_0000, 16);
        wait_idle;
        cmd(8'h06, 24'h00_0000, 8);
        cmd(8'hC7, 24'h00_0000, 8);
        wait_idle;
        check("bulk", 2'h3, last_entry[33:32]);
        $display("test hardware protect done");
        tx[4] = 8'hA1;
        tx[5] = 8'hB2;
        tx[6] = 8'hC3;
        stall = 1'b1;
        hv_detect = 1'b1;
        n0 = n_taken;
        cmd(8'h06, 24'h00_0000, 8);
        cmd(8'h02, 24'h00_00FE, 56);
        cmd(8'h06, 24'h00_0000, 8);
        ticks(100);
        stall = 1'b0;
        wait_idle;
        check("program", {n0 + 8'h03, 34'h1_0000_00C3},
            {n_taken, last_entry});
        check("after program", 2'b10, {saw_fast, latch});
        $display("test program done");
        give_verdict;
    end
endmodule
